// ### src/tsc_pkg.sv
// constants and types shared by the trigger and synchronisation control block
package tsc_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_CMD = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_IFCFG = 5'h10;
   // control register fields
   localparam int CTRL_TMODE_LSB = 0;
   localparam int CTRL_TPOL_BIT = 2;
   localparam int CTRL_SMODE_LSB = 4;
   localparam int CTRL_SPOL_BIT = 6;
   // command register fields
   localparam int CMD_SWTRIG_BIT = 0;
   localparam int CMD_SAVE_BIT = 1;
   localparam int CMD_LOAD_BIT = 2;
   localparam int CMD_SLOT_LSB = 4;
   localparam int CMD_SCOPE_LSB = 8;
   // status register fields
   localparam int STAT_REMAIN_LSB = 0;
   localparam int STAT_RUN_LSB = 16;
   localparam int STAT_REFUSED_BIT = 18;
   // output count setting
   localparam int COUNT_W = 14;
   localparam logic [COUNT_W-1:0] COUNT_STOP = 14'h0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 14'h0001;
   localparam logic [COUNT_W-1:0] COUNT_ENDLESS = 14'h3FFF;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 14'h0001;
   localparam int IFCFG_W = 16;
   localparam logic [IFCFG_W-1:0] IFCFG_RESET = 16'h0000;
   localparam int SLOTS = 8;
   localparam int SLOT_W = 3;
   // internal synchronisation rate
   localparam int CLK_PERIOD_NS = 100;
   localparam int SYNC_PERIOD_NS = 10000;
   localparam int SYNC_DIV = SYNC_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      TSC_TRIG_NONE = 2'h0,
      TSC_TRIG_LEVEL = 2'h1,
      TSC_TRIG_EDGE = 2'h2,
      TSC_TRIG_SOFT = 2'h3
   } tsc_trig_e;

   typedef enum logic [1:0] {
      TSC_SYNC_NONE = 2'h0,
      TSC_SYNC_INT = 2'h1,
      TSC_SYNC_EXT = 2'h2,
      TSC_SYNC_RSVD = 2'h3
   } tsc_sync_e;

   typedef enum logic [1:0] {
      TSC_SCOPE_ALL = 2'h0,
      TSC_SCOPE_IF = 2'h1,
      TSC_SCOPE_MEAS = 2'h2,
      TSC_SCOPE_RSVD = 2'h3
   } tsc_scope_e;

   typedef enum logic [1:0] {
      TSC_RUN_IDLE = 2'b00,
      TSC_RUN_COUNT = 2'b01,
      TSC_RUN_ENDLESS = 2'b11
   } tsc_run_e;
endpackage

// ### src/tsc_trigger_sync.sv
// trigger, synchronisation master and setup slot control with output fifo
`timescale 1ns/1ps
`default_nettype none

module tsc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] cnt_reg;
   logic [AW:0] cnt_next;
   logic in_ready_reg;
   logic push;
   logic pop;

   assign push = in_valid && in_ready_reg;
   assign pop = out_valid && out_ready;
   assign in_ready = in_ready_reg;
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];

   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cnt_reg <= '0;
         in_ready_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         in_ready_reg <= (cnt_next != FULL);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
endmodule // tsc_fifo

module tsc_trigger_sync import tsc_pkg::*; #(
   parameter int FIFO_DEPTH = 8,
   parameter int SAMPLE_W = 32
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trig_in,
   input wire logic sync_in,
   output logic sensor_sync,
   input wire logic meas_valid,
   output logic meas_ready,
   input wire logic [SAMPLE_W-1:0] meas_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [SAMPLE_W-1:0] out_data,
   output logic [IFCFG_W-1:0] iface_cfg
);
   localparam logic [7:0] DIV_LAST = 8'(SYNC_DIV - 1);
   localparam int MEAS_W = 2 + 1 + 2 + 1 + COUNT_W;
   // layout of a measuring slot word, count in the low bits
   localparam int M_SPOL = COUNT_W;
   localparam int M_SMODE = COUNT_W + 1;
   localparam int M_TPOL = COUNT_W + 3;
   localparam int M_TMODE = COUNT_W + 4;

   function automatic logic hw_trig(input logic [1:0] mode);
      return (mode == TSC_TRIG_LEVEL) || (mode == TSC_TRIG_EDGE);
   endfunction

   // bus slave state
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic wr_do;
   logic wr_ctrl;
   logic wr_count;
   logic wr_cmd;
   logic wr_ifcfg;

   // settings
   tsc_trig_e trig_mode_reg;
   logic trig_pol_reg;
   tsc_sync_e sync_mode_reg;
   logic sync_pol_reg;
   logic [COUNT_W-1:0] count_reg;
   logic [IFCFG_W-1:0] ifcfg_reg;
   logic refused_reg;
   logic [MEAS_W-1:0] meas_slot_reg [SLOTS];
   logic [IFCFG_W-1:0] if_slot_reg [SLOTS];
   logic [MEAS_W-1:0] meas_now;
   logic [MEAS_W-1:0] meas_ld;
   logic [SLOT_W-1:0] cmd_slot;
   tsc_scope_e cmd_scope;
   logic cmd_load;
   logic cmd_save;

   // run control
   tsc_run_e run_reg;
   logic [COUNT_W-1:0] remain_reg;
   logic trig_prev_reg;
   logic sync_prev_reg;
   logic [7:0] div_reg;
   logic sync_reg;
   logic trig_event;
   logic stop_req;
   logic gate;
   logic push;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [SAMPLE_W-1:0] fifo_out_data;
   logic out_valid_reg;
   logic [SAMPLE_W-1:0] out_data_reg;
   logic [DATA_W-1:0] rd_word;

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready = !w_held_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_ctrl = wr_do && (awaddr_reg == OFF_CTRL);
   assign wr_count = wr_do && (awaddr_reg == OFF_COUNT);
   assign wr_cmd = wr_do && (awaddr_reg == OFF_CMD);
   assign wr_ifcfg = wr_do && (awaddr_reg == OFF_IFCFG);
   assign cmd_slot = wdata_reg[CMD_SLOT_LSB +: SLOT_W];
   assign cmd_scope = tsc_scope_e'(wdata_reg[CMD_SCOPE_LSB +: 2]);
   assign cmd_save = wr_cmd && wdata_reg[CMD_SAVE_BIT];
   assign cmd_load = wr_cmd && wdata_reg[CMD_LOAD_BIT];
   assign meas_now = {trig_mode_reg, trig_pol_reg, sync_mode_reg,
                      sync_pol_reg, count_reg};
   assign meas_ld = meas_slot_reg[cmd_slot];

   // address and data are latched separately, in either order
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
         end
         if (wr_do) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_ctrl || wr_count || wr_cmd || wr_ifcfg) ?
                         RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_word = '0;
      case (s_axi_araddr)
         OFF_CTRL: begin
            rd_word[CTRL_TMODE_LSB +: 2] = trig_mode_reg;
            rd_word[CTRL_TPOL_BIT] = trig_pol_reg;
            rd_word[CTRL_SMODE_LSB +: 2] = sync_mode_reg;
            rd_word[CTRL_SPOL_BIT] = sync_pol_reg;
         end
         OFF_COUNT: rd_word[COUNT_W-1:0] = count_reg;
         OFF_STATUS: begin
            rd_word[STAT_REMAIN_LSB +: COUNT_W] = remain_reg;
            rd_word[STAT_RUN_LSB +: 2] = run_reg;
            rd_word[STAT_REFUSED_BIT] = refused_reg;
         end
         OFF_IFCFG: rd_word[IFCFG_W-1:0] = ifcfg_reg;
         default: rd_word = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= (s_axi_araddr == OFF_CMD ||
                       s_axi_araddr == OFF_CTRL ||
                       s_axi_araddr == OFF_COUNT ||
                       s_axi_araddr == OFF_STATUS ||
                       s_axi_araddr == OFF_IFCFG) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // active settings: bus writes and slot loads
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         trig_mode_reg <= TSC_TRIG_NONE;
         trig_pol_reg <= 1'b1;
         sync_mode_reg <= TSC_SYNC_NONE;
         sync_pol_reg <= 1'b1;
         count_reg <= COUNT_RESET;
         ifcfg_reg <= IFCFG_RESET;
         refused_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            // a mix of hardware trigger and external sync is refused
            if (hw_trig(wdata_reg[CTRL_TMODE_LSB +: 2]) &&
                wdata_reg[CTRL_SMODE_LSB +: 2] == TSC_SYNC_EXT) begin
               refused_reg <= 1'b1;
            end else begin
               refused_reg <= 1'b0;
               trig_mode_reg <=
                  tsc_trig_e'(wdata_reg[CTRL_TMODE_LSB +: 2]);
               trig_pol_reg <= wdata_reg[CTRL_TPOL_BIT];
               sync_mode_reg <=
                  tsc_sync_e'(wdata_reg[CTRL_SMODE_LSB +: 2]);
               sync_pol_reg <= wdata_reg[CTRL_SPOL_BIT];
            end
         end
         if (wr_count) begin
            count_reg <= wdata_reg[COUNT_W-1:0];
         end
         if (wr_ifcfg) begin
            ifcfg_reg <= wdata_reg[IFCFG_W-1:0];
         end
         if (cmd_load) begin
            if (cmd_scope != TSC_SCOPE_MEAS) begin
               ifcfg_reg <= if_slot_reg[cmd_slot];
            end
            if (cmd_scope != TSC_SCOPE_IF) begin
               trig_mode_reg <= tsc_trig_e'(meas_ld[M_TMODE +: 2]);
               trig_pol_reg <= meas_ld[M_TPOL];
               sync_mode_reg <= tsc_sync_e'(meas_ld[M_SMODE +: 2]);
               sync_pol_reg <= meas_ld[M_SPOL];
               count_reg <= meas_ld[COUNT_W-1:0];
            end
         end
      end
   end

   // eight setup slots, index 0..7 stands for setup 1..8
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         for (int i = 0; i < SLOTS; i++) begin
            meas_slot_reg[i] <= {TSC_TRIG_NONE, 1'b1, TSC_SYNC_NONE, 1'b1,
                                 COUNT_RESET};
            if_slot_reg[i] <= IFCFG_RESET;
         end
      end else if (cmd_save) begin
         meas_slot_reg[cmd_slot] <= meas_now;
         if_slot_reg[cmd_slot] <= ifcfg_reg;
      end
   end

   // trigger events and the run state
   assign trig_event =
      (trig_mode_reg == TSC_TRIG_EDGE && trig_in == trig_pol_reg &&
       trig_prev_reg != trig_pol_reg) ||
      (trig_mode_reg == TSC_TRIG_SOFT && wr_cmd &&
       wdata_reg[CMD_SWTRIG_BIT]);
   assign stop_req = wr_count && wdata_reg[COUNT_W-1:0] == COUNT_STOP;

   always_comb begin
      case (trig_mode_reg)
         TSC_TRIG_NONE: gate = 1'b1;
         TSC_TRIG_LEVEL: gate = (trig_in == trig_pol_reg);
         default: gate = (run_reg != TSC_RUN_IDLE);
      endcase
   end

   assign push = meas_valid && fifo_in_ready && gate;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         run_reg <= TSC_RUN_IDLE;
         remain_reg <= '0;
      end else if (stop_req || cmd_load) begin
         run_reg <= TSC_RUN_IDLE;
         remain_reg <= '0;
      end else if (trig_event && count_reg == COUNT_ENDLESS) begin
         run_reg <= TSC_RUN_ENDLESS;
      end else if (trig_event && count_reg != COUNT_STOP) begin
         run_reg <= TSC_RUN_COUNT;
         remain_reg <= count_reg;
      end else if (run_reg == TSC_RUN_COUNT && push) begin
         remain_reg <= remain_reg - COUNT_ONE;
         if (remain_reg == COUNT_ONE) begin
            run_reg <= TSC_RUN_IDLE;
         end
      end else if (trig_mode_reg == TSC_TRIG_NONE ||
                   trig_mode_reg == TSC_TRIG_LEVEL) begin
         run_reg <= TSC_RUN_IDLE;
      end
   end

   // sensor synchronisation master
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         trig_prev_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
      end else begin
         trig_prev_reg <= trig_in;
         sync_prev_reg <= sync_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         div_reg <= '0;
      end else if (sync_mode_reg != TSC_SYNC_INT || div_reg == DIV_LAST) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sync_reg <= 1'b0;
      end else begin
         case (sync_mode_reg)
            TSC_SYNC_INT: sync_reg <= (div_reg == DIV_LAST);
            TSC_SYNC_EXT: sync_reg <= (sync_in == sync_pol_reg &&
                                       sync_prev_reg != sync_pol_reg);
            default: sync_reg <= 1'b0;
         endcase
      end
   end

   assign sensor_sync = sync_reg;
   assign iface_cfg = ifcfg_reg;

   tsc_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(meas_valid && gate),
      .in_ready(fifo_in_ready),
      .in_data(meas_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   assign meas_ready = fifo_in_ready;
   assign fifo_out_ready = !out_valid_reg || out_ready;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end else if (fifo_out_ready) begin
         out_valid_reg <= fifo_out_valid;
         out_data_reg <= fifo_out_data;
      end
   end

   assign out_valid = out_valid_reg;
   assign out_data = out_data_reg;
endmodule // tsc_trigger_sync

`default_nettype wire

// ### tb/tsc_sensor_model.sv
// sensor side model: free running, or one value per master sync pulse
`timescale 1ns/1ps
`default_nettype none
module tsc_sensor_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic free_run,
   input wire logic sensor_sync,
   input wire logic meas_ready,
   output logic meas_valid,
   output logic [31:0] meas_data
);
   logic [31:0] seq_reg;
   // a slaved sensor offers one value per master pulse
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         meas_valid <= 1'b0;
         seq_reg <= 32'h1;
      end else if (meas_valid && meas_ready) begin
         meas_valid <= free_run;
         seq_reg <= seq_reg + 32'h1;
      end else if (free_run || sensor_sync) begin
         meas_valid <= 1'b1;
      end
   end
   // no stale value while nothing is offered
   assign meas_data = meas_valid ? seq_reg : ~seq_reg;
endmodule // tsc_sensor_model
`default_nettype wire

// ### tb/tsc_trigger_sync_properties.sv
// port checks for the trigger and sync control block
`timescale 1ns/1ps
`default_nettype none
module tsc_trigger_sync_properties #(
   parameter int SAMPLE_W = 32
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sensor_sync,
   input wire logic meas_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [SAMPLE_W-1:0] out_data
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   sequence s_write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_idle_then_ready;
      !s_axi_bvalid && !s_axi_rvalid && !out_valid && !sensor_sync
         && !meas_ready ##1 meas_ready;
   endsequence
   AST_WRITE_ANSWER: assert property (s_write_taken |-> ##2 s_axi_bvalid)
      else $error("no write response two cycles after address and data");
   AST_BVALID_CAUSE: assert property ($rose(s_axi_bvalid) |->
      $past(!s_axi_awready && !s_axi_wready))
      else $error("write response without address and data held");
   AST_BVALID_ONCE: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write response repeated");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("no read data one cycle after address");
   AST_RVALID_ONCE: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("read data repeated");
   AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   AST_SYNC_PULSE: assert property (sensor_sync |=> !sensor_sync)
      else $error("sensor sync longer than one cycle");
   AST_OUT_HOLD: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_data)) else $error("output dropped");
   AST_FULL_STALL: assert property ($fell(meas_ready) |-> out_valid)
      else $error("input refused with no output waiting");
   AST_RESET_STATE: assert property ($rose(reset_n) |-> s_idle_then_ready)
      else $error("outputs not idle after reset");
endmodule // tsc_trigger_sync_properties
bind tsc_trigger_sync tsc_trigger_sync_properties #(.SAMPLE_W(SAMPLE_W))
   u_props (.mclk(mclk), .reset_n(reset_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .sensor_sync(sensor_sync), .meas_ready(meas_ready),
   .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
`default_nettype wire

// ### tb/tsc_trigger_sync_tb.sv
// self-checking bench for the trigger and sync control block
`timescale 1ns/1ps
`default_nettype none
module tsc_trigger_sync_tb import tsc_pkg::*; ;
   logic mclk, reset_n, trig_in, sync_in, free_run, out_ready;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, sensor_sync, meas_valid;
   logic meas_ready, out_valid;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
   logic [31:0] meas_data, out_data;
   logic [IFCFG_W-1:0] iface_cfg;
   logic [31:0] q[$];
   int miscompares = 0, cmp_count = 0, n_out = 0, n_sync = 0;
   int cyc = 0, t_sync = 0;
   tsc_trigger_sync #(.FIFO_DEPTH(8), .SAMPLE_W(32)) dut (.*);
   tsc_sensor_model u_sensor (.*);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         n_out++;
         q.push_back(out_data);
      end
      if (sensor_sync === 1'b1) begin
         n_sync++;
         t_sync = cyc;
      end
   end
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic hang;
      miscompares++;
      $display("CHECK FAILED %0t wait ran out", $time);
      summarize();
   endtask
   task automatic check(input logic [31:0] seen, exp, input string m);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      bs = s_axi_bresp;
      if (n == 50) hang();
   endtask
   task automatic rdr(input logic [ADDR_W-1:0] a);
      int n;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (n == 50) hang();
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      rdr(a);
      check(rd, e, "register read");
   endtask
   task automatic wsync;
      int k, n;
      k = n_sync;
      for (n = 0; n < 300 && n_sync == k; n++) tick(1);
      if (n_sync == k) hang();
   endtask
   task automatic t_regs;
      rchk(OFF_COUNT, 32'h1);
      rchk(OFF_IFCFG, 32'h0);
      rchk(OFF_CMD, 32'h0);
      rdr(5'h14);
      check(rs, RESP_SLVERR, "unmapped response");
      check(rd, 32'h0, "unmapped data");
      wr(5'h14, 32'h0);
      check(bs, RESP_SLVERR, "unmapped write");
      wr(OFF_IFCFG, 32'h0);
      check(bs, RESP_OKAY, "mapped write");
      $display("test regs done");
   endtask
   task automatic t_edge;
      int cnt[3] = '{1, 3, 16382};
      int n0;
      wr(OFF_CTRL, 32'h6);
      foreach (cnt[i]) begin
         wr(OFF_COUNT, cnt[i]);
         tick(20);
         n0 = n_out;
         trig_in <= 1'b1;
         tick(cnt[i] + 40);
         check(n_out - n0, cnt[i], "counted run");
         trig_in <= 1'b0;
      end
      wr(OFF_CTRL, 32'h2);
      wr(OFF_COUNT, 32'h3);
      trig_in <= 1'b1;
      tick(20);
      n0 = n_out;
      trig_in <= 1'b0;
      tick(40);
      check(n_out - n0, 3, "falling edge run");
      wr(OFF_COUNT, 32'h3FFF);
      trig_in <= 1'b1;
      tick(5);
      n0 = n_out;
      trig_in <= 1'b0;
      tick(60);
      check(n_out - n0 > 40, 1, "endless run");
      wr(OFF_COUNT, 32'h0);
      tick(20);
      n0 = n_out;
      tick(40);
      check(n_out - n0, 0, "stop code");
      rdr(OFF_STATUS);
      check(rd[17:16], 2'h0, "run idle");
      $display("test edge done");
   endtask
   task automatic t_soft_level;
      int n0;
      wr(OFF_CTRL, 32'h7);
      wr(OFF_COUNT, 32'h2);
      tick(20);
      n0 = n_out;
      trig_in <= 1'b1;
      tick(30);
      check(n_out - n0, 0, "pin ignored");
      wr(OFF_CMD, 32'h1);
      tick(40);
      check(n_out - n0, 2, "software run");
      wr(OFF_CTRL, 32'h1);
      tick(20);
      n0 = n_out;
      tick(30);
      check(n_out - n0, 0, "level inactive");
      trig_in <= 1'b0;
      tick(30);
      check(n_out - n0 > 20, 1, "level active");
      trig_in <= 1'b1;
      tick(15);
      n0 = n_out;
      tick(30);
      check(n_out - n0, 0, "level removed");
      wr(OFF_CTRL, 32'h0);
      tick(30);
      check(n_out - n0 > 20, 1, "no trigger");
      $display("test soft and level done");
   endtask
   task automatic t_excl_sync;
      int n0, t1;
      wr(OFF_CTRL, 32'h21);
      rdr(OFF_STATUS);
      check(rd[18], 1'b1, "refused flag");
      wr(OFF_CTRL, 32'h22);
      rchk(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'h60);
      rdr(OFF_STATUS);
      check(rd[18], 1'b0, "refused cleared");
      rchk(OFF_CTRL, 32'h60);
      tick(10);
      n0 = n_sync;
      sync_in <= 1'b1;
      tick(30);
      check(n_sync - n0, 1, "one pulse per edge");
      sync_in <= 1'b0;
      tick(30);
      check(n_sync - n0, 1, "wrong edge");
      free_run <= 1'b0;
      wr(OFF_CTRL, 32'h10);
      wsync();
      t1 = t_sync;
      tick(10);
      n0 = n_out;
      wsync();
      check(t_sync - t1, SYNC_DIV, "internal period");
      tick(10);
      check(n_out - n0, 1, "slave value per pulse");
      wr(OFF_CTRL, 32'h0);
      free_run <= 1'b1;
      n0 = n_sync;
      tick(250);
      check(n_sync - n0, 0, "sync off");
      $display("test exclusion and sync done");
   endtask
   task automatic t_slots;
      wr(OFF_IFCFG, 32'h1234);
      wr(OFF_COUNT, 32'h5);
      wr(OFF_CMD, 32'h72);
      wr(OFF_IFCFG, 32'h5555);
      wr(OFF_COUNT, 32'h9);
      wr(OFF_CMD, 32'h174);
      rchk(OFF_IFCFG, 32'h1234);
      check(iface_cfg, 16'h1234, "interface port");
      rchk(OFF_COUNT, 32'h9);
      wr(OFF_CMD, 32'h274);
      rchk(OFF_COUNT, 32'h5);
      wr(OFF_IFCFG, 32'h7);
      wr(OFF_COUNT, 32'h7);
      wr(OFF_CMD, 32'h74);
      rchk(OFF_IFCFG, 32'h1234);
      rchk(OFF_COUNT, 32'h5);
      wr(OFF_CMD, 32'h4);
      rchk(OFF_IFCFG, 32'h0);
      rchk(OFF_COUNT, 32'h1);
      $display("test slots done");
   endtask
   task automatic t_fifo;
      int n;
      out_ready <= 1'b0;
      for (n = 0; n < 40 && meas_ready !== 1'b0; n++) tick(1);
      check(meas_ready, 1'b0, "full fifo refuses");
      q.delete();
      out_ready <= 1'b1;
      tick(30);
      check(q.size() > 8, 1, "drained");
      for (n = 0; n < 8; n++) check(q[n + 1], q[n] + 1, "fifo order");
      free_run <= 1'b0;
      tick(20);
      check(out_valid, 1'b0, "fifo empty");
      $display("test fifo done");
   endtask
   initial begin
      reset_n = 1'b0;
      trig_in = 1'b0;
      sync_in = 1'b0;
      free_run = 1'b1;
      out_ready = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      tick(6);
      reset_n <= 1'b1;
      t_regs();
      t_edge();
      t_soft_level();
      t_excl_sync();
      t_slots();
      t_fifo();
      summarize();
   end
   initial begin
      tick(60000);
      hang();
   end
endmodule // tsc_trigger_sync_tb
`default_nettype wire
